// ==== common/ufc_pkg.sv ====
// constants, layouts and state type of the fifo control block
package ufc_pkg;
  localparam int          DEPTH       = 16;
  localparam logic [4:0]  FIFO_FULL   = 5'h10;
  // byte addresses of the register words
  localparam logic [4:0]  REG_CTRL    = 5'h00;
  localparam logic [4:0]  REG_COUNT   = 5'h04;
  localparam logic [4:0]  REG_TXDATA  = 5'h08;
  localparam logic [4:0]  REG_RXDATA  = 5'h0C;
  localparam logic [4:0]  REG_STATUS  = 5'h10;
  localparam logic [4:0]  REG_BAUD    = 5'h14;
  // fifo_control fields
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam int          B_LOOP      = 0;
  localparam int          B_RXFL      = 1;
  localparam int          B_TXFL      = 2;
  localparam int          B_MCE       = 3;
  localparam int          F_TTRG      = 4;
  localparam int          F_RTRG      = 6;
  // fifo_occupancy_count fields
  localparam int          CNT_TX_LSB  = 8;
  localparam int          CNT_RX_LSB  = 0;
  // status bits
  localparam int          S_RXLVL     = 0;
  localparam int          S_TXLOW     = 1;
  localparam int          S_CTSOK     = 2;
  localparam int          S_TXFULL    = 3;
  localparam int          S_RXEMPTY   = 4;
  // baud config fields
  localparam int          BAUD_PRE    = 8;
  localparam int          BAUD_EXT    = 10;
  // trigger levels
  localparam logic [4:0]  RX_TRIG_0   = 5'h01;
  localparam logic [4:0]  RX_TRIG_1   = 5'h04;
  localparam logic [4:0]  RX_TRIG_2   = 5'h08;
  localparam logic [4:0]  RX_TRIG_3   = 5'h0E;
  localparam logic [4:0]  TX_TRIG_0   = 5'h08;
  localparam logic [4:0]  TX_TRIG_1   = 5'h04;
  localparam logic [4:0]  TX_TRIG_2   = 5'h02;
  localparam logic [4:0]  TX_TRIG_3   = 5'h01;
  localparam logic [4:0]  RTS_STOP    = 5'h0F;
  // timing: bit rate is mclk/32 at divisor 0, 16 samples per bit
  localparam int          CLK_HZ      = 100000000;
  localparam int          INT_DIV     = 32;
  localparam logic [3:0]  SAMP_LAST   = 4'hF;
  localparam logic [15:0] SAMP_BASE   = 16'(INT_DIV / 16);

  typedef struct packed {
    logic [7:0]            ctrl;
    logic [7:0]            baud_div;
    logic [1:0]            baud_pre;
    logic                  ext_clk;
    logic [15:0][7:0]      txmem;
    logic [3:0]            tx_rd;
    logic [3:0]            tx_wr;
    logic [4:0]            tx_cnt;
    logic [15:0][7:0]      rxmem;
    logic [3:0]            rx_rd;
    logic [3:0]            rx_wr;
    logic [4:0]            rx_cnt;
    logic [1:0][7:0]       rxb;
    logic [1:0]            rxb_cnt;
    logic [15:0]           tick_cnt;
    logic [3:0]            samp_cnt;
    logic [1:0]            rxd_s;
    logic [1:0]            cts_s;
    logic [2:0]            sck_s;
    logic                  ack;
    logic                  waitrequest;
    logic [31:0]           readdata;
    logic                  tx_valid;
    logic [7:0]            tx_data;
    logic                  rx_in_ready;
    logic                  rx_serial;
    logic                  txd;
    logic                  rts_n;
    logic                  rx_level;
    logic                  tx_low;
    logic                  sample_tick;
    logic                  bit_tick;
  } ufc_state_t;

  function automatic logic [4:0] rx_trig(input logic [1:0] s);
    case (s)
      2'h0:    rx_trig = RX_TRIG_0;
      2'h1:    rx_trig = RX_TRIG_1;
      2'h2:    rx_trig = RX_TRIG_2;
      default: rx_trig = RX_TRIG_3;
    endcase
  endfunction

  function automatic logic [4:0] tx_trig(input logic [1:0] s);
    case (s)
      2'h0:    tx_trig = TX_TRIG_0;
      2'h1:    tx_trig = TX_TRIG_1;
      2'h2:    tx_trig = TX_TRIG_2;
      default: tx_trig = TX_TRIG_3;
    endcase
  endfunction
endpackage

// ==== core/ufc_top.sv ====
// fifo control, occupancy count, handshake, loop-back and baud ticks
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - rx flag when count exceeds trigger
// - tx flag when count below trigger
// - handshake off: cts active, rts low
// - tx flush empties transmit fifo
// - rx flush empties receive fifo
// - reset or standby clears control, fifos
// - control register always readable, writable; a control write during standby is lost, standby clears it to CTRL_RST
// - loop-back feeds transmit into receive
// - count register: tx high, rx low
// - tx count bits 12..8, rest zero
// - rx count bits 4..0, rest zero
// - count register always readable
// - internal divisor zero gives mclk/32
// - external clock /16, max mclk/4
module ufc_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        standby,
  // avalon-mm slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // to transmit shift register
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  input  wire logic        tx_ready,
  input  wire logic        txd_shift,
  // from receive shift register
  input  wire logic        rx_in_valid,
  input  wire logic [7:0]  rx_in_data,
  output logic             rx_in_ready,
  output logic             rx_serial,
  // pins
  input  wire logic        rxd,
  input  wire logic        cts_n,
  input  wire logic        sck,
  output logic             txd,
  output logic             rts_n,
  // flags and ticks
  output logic             rx_level_reached_flag,
  output logic             tx_level_low_flag,
  output logic             sample_tick,
  output logic             bit_tick
);
  ufc_pkg::ufc_state_t q;
  ufc_pkg::ufc_state_t n;

  logic        wr_go;
  logic        rd_go;
  logic        cts_ok;
  logic        tx_push;
  logic        tx_pop;
  logic        rx_drain;
  logic        rx_push;
  logic        rx_pop;
  logic        tick;
  logic [15:0] lim;
  logic [31:0] rdval;

  always_comb begin
    n = q;
    // pins pass two flops before anything reads them
    n.rxd_s = {q.rxd_s[0], rxd};
    n.cts_s = {q.cts_s[0], cts_n};
    n.sck_s = {q.sck_s[1:0], sck};
    cts_ok = !q.ctrl[ufc_pkg::B_MCE] || !q.cts_s[1];

    // register read mux, sampled when the request is first seen
    rdval = 32'h0000_0000;
    unique case (address)
      ufc_pkg::REG_CTRL:   rdval[7:0] = q.ctrl;
      ufc_pkg::REG_COUNT: begin
        // upper bits of each byte stay zero
        rdval[ufc_pkg::CNT_TX_LSB +: 5] = q.tx_cnt;
        rdval[ufc_pkg::CNT_RX_LSB +: 5] = q.rx_cnt;
      end
      ufc_pkg::REG_RXDATA: begin
        if (q.rx_cnt != 5'h00) begin
          rdval[7:0] = q.rxmem[q.rx_rd];
        end
      end
      ufc_pkg::REG_STATUS: begin
        rdval[ufc_pkg::S_RXLVL]   = q.rx_level;
        rdval[ufc_pkg::S_TXLOW]   = q.tx_low;
        rdval[ufc_pkg::S_CTSOK]   = cts_ok;
        rdval[ufc_pkg::S_TXFULL]  = q.tx_cnt == ufc_pkg::FIFO_FULL;
        rdval[ufc_pkg::S_RXEMPTY] = q.rx_cnt == 5'h00;
      end
      ufc_pkg::REG_BAUD: begin
        rdval[7:0]                  = q.baud_div;
        rdval[ufc_pkg::BAUD_PRE +: 2] = q.baud_pre;
        rdval[ufc_pkg::BAUD_EXT]    = q.ext_clk;
      end
      default: rdval = 32'h0000_0000;
    endcase

    // one wait cycle, then the answer; side effects at completion edge
    n.ack         = 1'b0;
    n.waitrequest = 1'b1;
    if (!q.ack && (read || write)) begin
      n.ack         = 1'b1;
      n.waitrequest = 1'b0;
      n.readdata    = read ? rdval : 32'h0000_0000;
    end
    wr_go = q.ack && write;
    rd_go = q.ack && read;

    // register writes, accepted in any operating state except a control write during standby, which standby overrides
    if (wr_go && address == ufc_pkg::REG_CTRL && byteenable[0]) begin
      n.ctrl = writedata[7:0];
    end
    if (wr_go && address == ufc_pkg::REG_BAUD) begin
      if (byteenable[0]) begin
        n.baud_div = writedata[7:0];
      end
      if (byteenable[1]) begin
        n.baud_pre = writedata[ufc_pkg::BAUD_PRE +: 2];
        n.ext_clk  = writedata[ufc_pkg::BAUD_EXT];
      end
    end

    // transmit fifo; a write to a full fifo is dropped
    tx_push = wr_go && address == ufc_pkg::REG_TXDATA && byteenable[0]
              && q.tx_cnt != ufc_pkg::FIFO_FULL;
    tx_pop  = q.tx_valid && tx_ready;
    if (tx_push) begin
      n.txmem[q.tx_wr] = writedata[7:0];
      n.tx_wr          = q.tx_wr + 4'h1;
    end
    if (tx_pop) begin
      n.tx_rd = q.tx_rd + 4'h1;
    end
    n.tx_cnt = 5'(q.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop});

    // receive: two-entry buffer ahead of the fifo absorbs a full fifo
    rx_drain = q.rxb_cnt != 2'h0 && q.rx_cnt != ufc_pkg::FIFO_FULL;
    rx_push  = rx_in_valid && q.rx_in_ready;
    rx_pop   = rd_go && address == ufc_pkg::REG_RXDATA && q.rx_cnt != 5'h00;
    if (rx_drain) begin
      n.rxmem[q.rx_wr] = q.rxb[0];
      n.rx_wr          = q.rx_wr + 4'h1;
      n.rxb[0]         = q.rxb[1];
    end
    if (rx_push) begin
      n.rxb[2'(q.rxb_cnt - {1'b0, rx_drain})] = rx_in_data;
    end
    n.rxb_cnt = 2'(q.rxb_cnt + {1'b0, rx_push} - {1'b0, rx_drain});
    if (rx_pop) begin
      n.rx_rd = q.rx_rd + 4'h1;
    end
    n.rx_cnt = 5'(q.rx_cnt + {4'h0, rx_drain} - {4'h0, rx_pop});

    // standby clears control, and through the flushes below, the fifos
    if (standby) begin
      n.ctrl = ufc_pkg::CTRL_RST;
    end
    // flush acts on the edge that sets it and as long as it stays set
    if (standby || n.ctrl[ufc_pkg::B_TXFL]) begin
      n.tx_rd  = 4'h0;
      n.tx_wr  = 4'h0;
      n.tx_cnt = 5'h00;
    end
    // flush drops words still in the front buffer too
    if (standby || n.ctrl[ufc_pkg::B_RXFL]) begin
      n.rx_rd   = 4'h0;
      n.rx_wr   = 4'h0;
      n.rx_cnt  = 5'h00;
      n.rxb_cnt = 2'h0;
    end

    // outputs registered from the next state
    n.tx_data     = n.txmem[n.tx_rd];
    // cts is checked every cycle; valid may fall while cts is high
    // new enable, so the offer follows a handshake change on the same edge
    n.tx_valid    = n.tx_cnt != 5'h00
                    && (!n.ctrl[ufc_pkg::B_MCE] || !q.cts_s[1]);
    n.rx_in_ready = n.rxb_cnt != 2'h2;
    n.rx_level    = n.rx_cnt > ufc_pkg::rx_trig(n.ctrl[ufc_pkg::F_RTRG +: 2]);
    n.tx_low      = n.tx_cnt < ufc_pkg::tx_trig(n.ctrl[ufc_pkg::F_TTRG +: 2]);
    n.rts_n       = n.ctrl[ufc_pkg::B_MCE] && n.rx_cnt >= ufc_pkg::RTS_STOP;
    // pin held at mark while looped so the peer sees an idle line
    n.txd         = n.ctrl[ufc_pkg::B_LOOP] ? 1'b1 : txd_shift;
    n.rx_serial   = n.ctrl[ufc_pkg::B_LOOP] ? txd_shift : q.rxd_s[1];

    // sample tick: 16 per bit; internal period 2*(div+1)*4^pre cycles
    lim = 16'(((({8'h00, q.baud_div} + 16'h0001) << {q.baud_pre, 1'b0})
          * ufc_pkg::SAMP_BASE) - 16'h0001);
    tick = 1'b0;
    if (q.ext_clk) begin
      // sck rising edge; needs sck at most mclk/4 to be seen
      tick       = q.sck_s[1] && !q.sck_s[2];
      n.tick_cnt = 16'h0000;
    end else if (q.tick_cnt >= lim) begin
      tick       = 1'b1;
      n.tick_cnt = 16'h0000;
    end else begin
      n.tick_cnt = q.tick_cnt + 16'h0001;
    end
    n.sample_tick = tick;
    n.bit_tick    = tick && q.samp_cnt == ufc_pkg::SAMP_LAST;
    if (tick) begin
      n.samp_cnt = q.samp_cnt + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q             <= '0;
      q.waitrequest <= 1'b1;
      q.rxd_s       <= 2'h3;
      q.cts_s       <= 2'h3;
      q.tx_low      <= 1'b1;
      q.rx_in_ready <= 1'b1;
      q.rx_serial   <= 1'b1;
      q.txd         <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign readdata              = q.readdata;
  assign waitrequest           = q.waitrequest;
  assign tx_valid              = q.tx_valid;
  assign tx_data               = q.tx_data;
  assign rx_in_ready           = q.rx_in_ready;
  assign rx_serial             = q.rx_serial;
  assign txd                   = q.txd;
  assign rts_n                 = q.rts_n;
  assign rx_level_reached_flag = q.rx_level;
  assign tx_level_low_flag     = q.tx_low;
  assign sample_tick           = q.sample_tick;
  assign bit_tick              = q.bit_tick;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  property p_rx_flag;
    rx_level_reached_flag
      == (q.rx_cnt > ufc_pkg::rx_trig(q.ctrl[ufc_pkg::F_RTRG +: 2]));
  endproperty
  a_rx_flag: assert property (p_rx_flag)
    else $error("rx level flag disagrees with count");

  property p_tx_flag;
    tx_level_low_flag
      == (q.tx_cnt < ufc_pkg::tx_trig(q.ctrl[ufc_pkg::F_TTRG +: 2]));
  endproperty
  a_tx_flag: assert property (p_tx_flag)
    else $error("tx low flag disagrees with count");

  property p_no_handshake;
    !q.ctrl[ufc_pkg::B_MCE] |-> !rts_n && (tx_valid == (q.tx_cnt != 5'h00));
  endproperty
  a_no_handshake: assert property (p_no_handshake)
    else $error("handshake lines not neutral while disabled");

  property p_tx_flush;
    q.ctrl[ufc_pkg::B_TXFL] |-> q.tx_cnt == 5'h00 && !tx_valid;
  endproperty
  a_tx_flush: assert property (p_tx_flush)
    else $error("tx fifo not empty during flush");

  property p_rx_flush;
    q.ctrl[ufc_pkg::B_RXFL] |-> q.rx_cnt == 5'h00 ##1 q.rx_cnt == 5'h00 || !q.ctrl[ufc_pkg::B_RXFL];
  endproperty
  a_rx_flush: assert property (p_rx_flush)
    else $error("rx fifo not empty during flush");

  property p_standby;
    standby |=> q.ctrl == ufc_pkg::CTRL_RST && q.tx_cnt == 5'h00 && q.rx_cnt == 5'h00;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby did not clear control and fifos");

  property p_loop;
    q.ctrl[ufc_pkg::B_LOOP] |-> txd && rx_serial == $past(txd_shift);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loop-back path wrong");

  property p_count_read;
    (read && !waitrequest && address == ufc_pkg::REG_COUNT)
      |-> readdata[15:13] == 3'h0 && readdata[7:5] == 3'h0
          && readdata[12:8] <= ufc_pkg::FIFO_FULL;
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("count register reserved bits set");

  property p_answer;
    ((read || write) && waitrequest) |-> ##[1:2] !waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus request not answered in two cycles");

  property p_int_rate;
    (sample_tick && !q.ext_clk && q.baud_div == 8'h00 && q.baud_pre == 2'h0
      && $stable(q.baud_div) && $stable(q.baud_pre))
      |-> ##1 !sample_tick ##1 (sample_tick || q.ext_clk || $changed(q.baud_div));
  endproperty
  a_int_rate: assert property (p_int_rate)
    else $error("internal sample tick not every two cycles");

  property p_ctrl_write;
    (write && !waitrequest && address == ufc_pkg::REG_CTRL && byteenable[0] && !standby)
      |=> q.ctrl == $past(writedata[7:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write did not land");

  property p_count_value;
    (read && !waitrequest && address == ufc_pkg::REG_COUNT)
      |-> readdata[ufc_pkg::CNT_TX_LSB +: 5] == $past(q.tx_cnt)
          && readdata[ufc_pkg::CNT_RX_LSB +: 5] == $past(q.rx_cnt);
  endproperty
  a_count_value: assert property (p_count_value)
    else $error("count register does not match fifo levels");

  property p_fifo_bounds;
    q.tx_cnt <= ufc_pkg::FIFO_FULL && q.rx_cnt <= ufc_pkg::FIFO_FULL;
  endproperty
  a_fifo_bounds: assert property (p_fifo_bounds)
    else $error("fifo count beyond depth");

  property p_rts_full;
    q.ctrl[ufc_pkg::B_MCE] |-> rts_n == (q.rx_cnt >= ufc_pkg::RTS_STOP);
  endproperty
  a_rts_full: assert property (p_rts_full)
    else $error("request-to-send does not follow receive level");

  property p_bit_tick;
    bit_tick |-> sample_tick;
  endproperty
  a_bit_tick: assert property (p_bit_tick)
    else $error("bit tick without sample tick");

endmodule
`default_nettype wire

// ==== test/ufc_peer.sv ====
// serial peer and shift-register stand-in facing the fifo control block
`timescale 1ns/1ns
`default_nettype none
module ufc_peer (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // bench controls
  input  wire logic       stall,
  input  wire logic       cts_off,
  input  wire logic       sck_on,
  // device side
  input  wire logic       rx_in_ready,
  output logic            tx_ready,
  output logic            txd_shift,
  output logic            rx_in_valid,
  output logic      [7:0] rx_in_data,
  // line side
  output logic            rxd,
  output logic            cts_n,
  output logic            sck
);
  logic [2:0] ph;
  assign tx_ready = !stall;
  assign cts_n    = cts_off;
  // mclk/4 at most, still unless enabled
  assign sck      = sck_on & ph[1];
  assign rxd      = ph[2];
  initial begin
    rx_in_valid = 1'b0;
    rx_in_data  = 8'h00;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ph        <= 3'h0;
      txd_shift <= 1'b1;
    end else begin
      ph        <= ph + 3'h1;
      txd_shift <= ph[0] ^ ph[2];
    end
  end
  task automatic push(input logic [7:0] b, output logic ok);
    int n;
    @(posedge mclk);
    rx_in_valid <= 1'b1;
    rx_in_data  <= b;
    n = 0;
    @(posedge mclk);
    while (rx_in_ready !== 1'b1 && n < 40) begin
      n++;
      @(posedge mclk);
    end
    ok = (rx_in_ready === 1'b1);
    rx_in_valid <= 1'b0;
    // released word must not linger on the bus
    rx_in_data  <= ~b;
  endtask
endmodule
`default_nettype wire

// ==== test/ufc_top_bench.sv ====
// self-checking bench for the fifo control block
`timescale 1ns/1ns
`default_nettype none
module ufc_top_bench;
  logic        mclk, reset_n, standby, read, write, stall, cts_off, sck_on, ok;
  logic        tx_valid, tx_ready, txd_shift, rx_in_valid, rx_in_ready, rx_serial;
  logic        rxd, cts_n, sck, txd, rts_n, rx_flag, tx_flag, sample_tick, bit_tick;
  logic        waitrequest;
  logic [4:0]  address;
  logic [7:0]  tx_data, rx_in_data;
  logic [31:0] writedata, readdata, q;
  int          bad_count = 0;
  int          total_checks = 0;

  ufc_top i_dut (.mclk(mclk), .reset_n(reset_n), .standby(standby), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .txd_shift(txd_shift), .rx_in_valid(rx_in_valid),
    .rx_in_data(rx_in_data), .rx_in_ready(rx_in_ready), .rx_serial(rx_serial), .rxd(rxd),
    .cts_n(cts_n), .sck(sck), .txd(txd), .rts_n(rts_n), .rx_level_reached_flag(rx_flag),
    .tx_level_low_flag(tx_flag), .sample_tick(sample_tick), .bit_tick(bit_tick));
  ufc_peer i_peer (.mclk(mclk), .reset_n(reset_n), .stall(stall), .cts_off(cts_off),
    .sck_on(sck_on), .rx_in_ready(rx_in_ready), .tx_ready(tx_ready), .txd_shift(txd_shift),
    .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data), .rxd(rxd), .cts_n(cts_n), .sck(sck));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic stop_test;
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    address   <= a;
    write     <= w;
    read      <= !w;
    writedata <= d;
    n = 0;
    @(posedge mclk);
    while (waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge mclk);
    end
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      chk(32'h1, 32'h0, "bus timeout");
      stop_test;
    end
  endtask

  task automatic cnt(input logic [4:0] t, input logic [4:0] r);
    bus(1'b0, ufc_pkg::REG_COUNT, 32'h0);
    chk(q, {19'h0, t, 3'h0, r}, "count");
  endtask

  task automatic ctl(input logic [7:0] v);
    bus(1'b1, ufc_pkg::REG_CTRL, {24'h0, v});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic t_reset;
    bus(1'b0, ufc_pkg::REG_CTRL, 32'h0);
    chk(q, 32'h0, "ctrl after reset");
    cnt(5'h00, 5'h00);
    bus(1'b0, ufc_pkg::REG_STATUS, 32'h0);
    // tx low, cts ok while handshake off, rx empty
    chk(q, 32'h16, "status after reset");
    chk(rts_n, 32'h0, "rts idle");
    chk(tx_flag, 32'h1, "tx low at empty");
    chk(rx_flag, 32'h0, "rx flag idle");
  endtask

  task automatic t_rx;
    logic [4:0] lv[4];
    lv = '{5'h01, 5'h04, 5'h08, 5'h0E};
    for (int s = 0; s < 4; s++) begin
      ctl({s[1:0], 6'h02});
      ctl({s[1:0], 6'h00});
      bus(1'b0, ufc_pkg::REG_CTRL, 32'h0);
      chk(q, {24'h0, s[1:0], 6'h00}, "ctrl readback");
      for (int i = 0; i < lv[s]; i++) i_peer.push(8'(i), ok);
      cyc(4);
      chk(rx_flag, 32'h0, "rx flag at level");
      i_peer.push({3'h0, lv[s]}, ok);
      cyc(4);
      chk(rx_flag, 32'h1, "rx flag above level");
      cnt(5'h00, lv[s] + 5'h01);
    end
    chk(rts_n, 32'h0, "rts held without handshake");
    ctl(8'hC8);
    cyc(4);
    chk(rts_n, 32'h1, "rts stops near full");
    for (int i = 15; i < 18; i++) i_peer.push(8'(i), ok);
    i_peer.push(8'hAA, ok);
    chk(ok, 32'h0, "buffer refuses when full");
    cnt(5'h00, 5'h10);
    for (int i = 0; i < 18; i++) begin
      bus(1'b0, ufc_pkg::REG_RXDATA, 32'h0);
      chk({24'h0, q[7:0]}, 32'(i), "rx order");
    end
    cyc(4);
    cnt(5'h00, 5'h00);
    i_peer.push(8'h5A, ok);
    ctl(8'h02);
    i_peer.push(8'h5B, ok);
    cyc(4);
    cnt(5'h00, 5'h00);
    ctl(8'h00);
  endtask

  task automatic t_tx;
    logic [4:0] lv[4];
    int         k;
    lv = '{5'h08, 5'h04, 5'h02, 5'h01};
    stall <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      ctl({2'h0, s[1:0], 4'h4});
      ctl({2'h0, s[1:0], 4'h0});
      for (int i = 1; i < lv[s]; i++) bus(1'b1, ufc_pkg::REG_TXDATA, 32'(i));
      cyc(3);
      chk(tx_flag, 32'h1, "tx low below level");
      bus(1'b1, ufc_pkg::REG_TXDATA, 32'h0);
      cyc(3);
      chk(tx_flag, 32'h0, "tx low at level");
      cnt(lv[s], 5'h00);
    end
    for (int i = 1; i < 17; i++) bus(1'b1, ufc_pkg::REG_TXDATA, 32'(i));
    cnt(5'h10, 5'h00);
    ctl(8'h34);
    cyc(2);
    chk(tx_valid, 32'h0, "flush stops offer");
    bus(1'b1, ufc_pkg::REG_TXDATA, 32'h77);
    cnt(5'h00, 5'h00);
    ctl(8'h30);
    cts_off <= 1'b1;
    for (int i = 0; i < 3; i++) bus(1'b1, ufc_pkg::REG_TXDATA, 32'hA1 + i);
    cyc(4);
    chk(tx_valid, 32'h1, "cts pin ignored");
    chk(tx_data, 32'hA1, "tx head");
    ctl(8'h38);
    cyc(6);
    chk(tx_valid, 32'h0, "cts honoured");
    cts_off <= 1'b0;
    stall   <= 1'b0;
    k = 0;
    for (int n = 0; n < 30 && k < 3; n++) begin
      @(posedge mclk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        chk(tx_data, 32'hA1 + k, "tx order");
        k++;
      end
    end
    chk(k, 32'h3, "tx drained");
    cnt(5'h00, 5'h00);
  endtask

  task automatic t_line(input logic lp);
    logic p;
    ctl({7'h0, lp});
    cyc(6);
    p = txd_shift;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      if (lp) chk(rx_serial, p, "loop feed");
      chk(txd, lp | p, "txd pin");
      p = txd_shift;
    end
    ctl(8'h00);
  endtask

  task automatic t_baud(input logic ext, input logic [7:0] dv, input int per);
    int n;
    int m;
    int s;
    sck_on <= ext;
    bus(1'b1, ufc_pkg::REG_BAUD, {21'h0, ext, 2'h0, dv});
    cyc(200);
    n = 0;
    m = 0;
    s = 0;
    for (int i = 0; i < 300 && m < 2; i++) begin
      @(posedge mclk);
      if (bit_tick === 1'b1) m++;
      if (m == 1) n++;
      if (m == 1 && sample_tick === 1'b1) s++;
    end
    chk(n, per, "bit period");
    chk(s, 32'h10, "samples per bit");
  endtask

  task automatic t_standby;
    stall <= 1'b1;
    ctl(8'hF8);
    bus(1'b1, ufc_pkg::REG_TXDATA, 32'h1);
    i_peer.push(8'h11, ok);
    standby <= 1'b1;
    cyc(2);
    standby <= 1'b0;
    bus(1'b0, ufc_pkg::REG_CTRL, 32'h0);
    chk(q, 32'h0, "standby clears ctrl");
    cnt(5'h00, 5'h00);
    // mid-run reset with settings and a queued byte in place
    ctl(8'hF0);
    bus(1'b1, ufc_pkg::REG_TXDATA, 32'h2);
    @(posedge mclk);
    reset_n <= 1'b0;
    cyc(2);
    reset_n <= 1'b1;
    bus(1'b0, ufc_pkg::REG_CTRL, 32'h0);
    chk(q, 32'h0, "reset clears ctrl");
    cnt(5'h00, 5'h00);
    chk(tx_flag, 32'h1, "tx low after reset");
  endtask

  initial begin
    reset_n   = 1'b0;
    standby   = 1'b0;
    read      = 1'b0;
    write     = 1'b0;
    address   = 5'h00;
    writedata = 32'h0;
    stall     = 1'b0;
    cts_off   = 1'b0;
    sck_on    = 1'b0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset;
    t_rx;
    t_tx;
    t_line(1'b1);
    t_line(1'b0);
    t_baud(1'b0, 8'h00, 32);
    t_baud(1'b0, 8'h01, 64);
    t_baud(1'b1, 8'h00, 64);
    t_standby;
    stop_test;
  end
endmodule
`default_nettype wire
